// >>> design/line_fmt_pkg.sv
// Register map, field layout and timing constants of the serial channel.
package line_fmt_pkg;
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_DIV_LOW = 3'h0;
	localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
	localparam logic [2:0] OFS_FIFO_CTRL = 3'h2;
	localparam logic [2:0] OFS_SAMPLE = 3'h2;
	localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_FLUSH = 1;
	localparam int FC_TX_FLUSH = 2;
	localparam int FC_TX_TRIG = 4;
	localparam int FC_RX_TRIG = 6;
	localparam int LC_LEN = 0;
	localparam int LC_STOP = 2;
	localparam int LC_PAR_EN = 3;
	localparam int LC_PAR_SEL = 4;
	localparam int LC_BREAK = 6;
	localparam int LC_DLAB = 7;
	localparam logic [7:0] LINE_CTRL_RST = 8'h03;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] DIVISOR_RST = 16'h0000;
	localparam logic [1:0] PAR_ODD = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_MARK = 2'h2;
	localparam logic [1:0] PAR_SPACE = 2'h3;
	localparam logic [1:0] LEN_5 = 2'h0;
	localparam logic [6:0] TX_TRIG_ENH [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
	localparam logic [6:0] RX_TRIG_STD [4] = '{7'h01, 7'h04, 7'h08, 7'h0E};
	localparam logic [6:0] RX_TRIG_ENH [4] = '{7'h0F, 7'h20, 7'h40, 7'h6F};
	localparam logic [6:0] TX_TRIG_STD = 7'h00;
	localparam logic [5:0] TICKS_BIT = 6'h10;
	localparam logic [5:0] TICKS_HALF = 6'h08;
	localparam logic [5:0] TICKS_STOP_15 = 6'h18;
	localparam logic [5:0] TICKS_STOP_2 = 6'h20;
	typedef enum logic [2:0] {
		SER_IDLE = 3'h0,
		SER_START = 3'h1,
		SER_DATA = 3'h3,
		SER_PARITY = 3'h2,
		SER_STOP = 3'h6
	} ser_state_e;
endpackage : line_fmt_pkg

// >>> design/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides, flush and fill count.
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("byte_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] count_ff;
	logic push;
	logic pop;

	assign in_ready = (count_ff != CW'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];
	assign count = count_ff;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	always_ff @(posedge mclk) begin
		if (srst || flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + AW'(1);
			if (push && !pop)
				count_ff <= count_ff + CW'(1);
			else if (pop && !push)
				count_ff <= count_ff - CW'(1);
		end
	end
endmodule : byte_fifo

// >>> design/serial_channel.sv
// Serial channel with FIFO control and character format registers.
// How it works
// - FIFO control bit 0 turns FIFO mode off or on and is off after reset.
// - Writing 1 to FIFO control bit 1 empties the receive FIFO once.
// - Writing 1 to FIFO control bit 2 empties the transmit FIFO once.
// - In enhanced mode bits 5:4 pick a transmit level of 16/32/64/112.
// - Outside enhanced mode bits 7:6 pick a receive level of 1/4/8/14.
// - In enhanced mode receive code 00 means 15 and code 11 means 111.
// - Line control bits 1:0 set 5 to 8 data bits, 8 after reset.
// - Line control bit 2 gives 1 stop bit, or 1.5 for 5 bits and 2 else.
// - Line control bit 6 holds the transmit line at space for a break.
// - Line control bit 7 selects divisor registers instead of data ones.
// - With divisor access, offsets 0, 1, 2 reach low, high and sample.
`timescale 1ns/1ps
module serial_channel
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic enhanced_mode,
	input wire logic rx_line,
	output logic tx_line,
	output logic rx_trigger_hit,
	output logic tx_trigger_low,
	output logic tx_fifo_full
);
	import line_fmt_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH + 1);

	initial begin
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64)
			$error("serial_channel: FIFO_DEPTH out of range");
	end

	logic fifo_en_ff, tick, dlab, wr_fifo_ctrl, rx_flush, tx_flush;
	logic tx_push, rx_pop;
	logic [1:0] tx_trig_ff, rx_trig_ff;
	logic [7:0] line_ctrl_ff, sample_ff, reg_rdata_ff;
	logic [15:0] divisor_ff, baud_cnt_ff;

	assign dlab = line_ctrl_ff[LC_DLAB];
	assign wr_fifo_ctrl = reg_wr && reg_addr == OFS_FIFO_CTRL && !dlab;
	// The flush bits are never stored, so they read back as cleared.
	assign rx_flush = wr_fifo_ctrl && reg_wdata[FC_RX_FLUSH];
	assign tx_flush = wr_fifo_ctrl && reg_wdata[FC_TX_FLUSH];
	assign tx_push = reg_wr && reg_addr == OFS_DATA && !dlab;
	assign rx_pop = reg_rd && reg_addr == OFS_DATA && !dlab;

	always_ff @(posedge mclk) begin
		if (srst) begin
			fifo_en_ff <= 1'b0;
			tx_trig_ff <= 2'h0;
			rx_trig_ff <= 2'h0;
		end else if (wr_fifo_ctrl) begin
			fifo_en_ff <= reg_wdata[FC_ENABLE];
			tx_trig_ff <= reg_wdata[FC_TX_TRIG +: 2];
			rx_trig_ff <= reg_wdata[FC_RX_TRIG +: 2];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			line_ctrl_ff <= LINE_CTRL_RST;
		else if (reg_wr && reg_addr == OFS_LINE_CTRL)
			line_ctrl_ff <= reg_wdata;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			divisor_ff <= DIVISOR_RST;
			sample_ff <= BYTE_ZERO;
		end else if (reg_wr && dlab) begin
			case (reg_addr)
				OFS_DIV_LOW: divisor_ff[7:0] <= reg_wdata;
				OFS_DIV_HIGH: divisor_ff[15:8] <= reg_wdata;
				OFS_SAMPLE: sample_ff <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Oversampling enable: one pulse every divisor cycles, none while zero.
	always_ff @(posedge mclk) begin
		if (srst || divisor_ff == DIVISOR_RST)
			baud_cnt_ff <= DIVISOR_RST;
		else if (baud_cnt_ff >= divisor_ff - 16'h0001)
			baud_cnt_ff <= DIVISOR_RST;
		else
			baud_cnt_ff <= baud_cnt_ff + 16'h0001;
	end
	assign tick = divisor_ff != DIVISOR_RST &&
		baud_cnt_ff >= divisor_ff - 16'h0001;

	// Character format decoded from the line control register.
	logic [2:0] last_bit;
	logic par_en;
	logic [5:0] stop_ticks;
	logic [7:0] len_mask;
	assign last_bit = 3'd4 + {1'b0, line_ctrl_ff[LC_LEN +: 2]};
	assign len_mask = 8'hFF >> (3'd7 - last_bit);
	assign par_en = line_ctrl_ff[LC_PAR_EN];
	always_comb begin
		if (!line_ctrl_ff[LC_STOP])
			stop_ticks = TICKS_BIT;
		else if (line_ctrl_ff[LC_LEN +: 2] == LEN_5)
			stop_ticks = TICKS_STOP_15;
		else
			stop_ticks = TICKS_STOP_2;
	end

	function automatic logic parity_of(input logic [7:0] d,
		input logic [1:0] sel);
		case (sel)
			PAR_ODD: parity_of = ~^d;
			PAR_EVEN: parity_of = ^d;
			PAR_MARK: parity_of = 1'b1;
			PAR_SPACE: parity_of = 1'b0;
			default: parity_of = 1'b1;
		endcase
	endfunction : parity_of

	// FIFOs; without FIFO mode each holds a single character.
	logic tx_in_ready, tx_out_valid, tx_take, rx_out_valid, rx_push_ff;
	logic [7:0] tx_out_data, rx_out_data, rx_shift_ff;
	logic [CW-1:0] tx_count, rx_count;

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(tx_flush),
		.in_valid(tx_push && (fifo_en_ff || tx_count == '0)),
		.in_ready(tx_in_ready),
		.in_data(reg_wdata),
		.out_valid(tx_out_valid),
		.out_ready(tx_take),
		.out_data(tx_out_data),
		.count(tx_count)
	);

	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(rx_flush),
		.in_valid(rx_push_ff && (fifo_en_ff || rx_count == '0)),
		.in_ready(),
		.in_data(rx_shift_ff & len_mask),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop),
		.out_data(rx_out_data),
		.count(rx_count)
	);

	// Trigger levels compared against the fill counts.
	logic [6:0] rx_level;
	logic [6:0] tx_level;
	always_comb begin
		if (!fifo_en_ff) begin
			rx_level = RX_TRIG_STD[0];
			tx_level = TX_TRIG_STD;
		end else if (enhanced_mode) begin
			rx_level = RX_TRIG_ENH[rx_trig_ff];
			tx_level = TX_TRIG_ENH[tx_trig_ff];
		end else begin
			rx_level = RX_TRIG_STD[rx_trig_ff];
			tx_level = TX_TRIG_STD;
		end
	end

	logic rx_hit_ff;
	logic tx_low_ff;
	logic tx_full_ff;
	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_hit_ff <= 1'b0;
			tx_low_ff <= 1'b1;
			tx_full_ff <= 1'b0;
		end else begin
			rx_hit_ff <= 7'(rx_count) >= rx_level;
			tx_low_ff <= 7'(tx_count) <= tx_level;
			tx_full_ff <= !tx_in_ready || (!fifo_en_ff && tx_count != '0);
		end
	end

	// Transmitter.
	ser_state_e tx_state_ff;
	logic [5:0] tx_tick_ff;
	logic [2:0] tx_bit_ff;
	logic [7:0] tx_shift_ff;
	logic tx_par_ff;
	logic tx_line_ff;
	assign tx_take = tx_state_ff == SER_IDLE && tx_out_valid;

	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_state_ff <= SER_IDLE;
			tx_tick_ff <= '0;
			tx_bit_ff <= '0;
			tx_shift_ff <= BYTE_ZERO;
			tx_par_ff <= 1'b0;
		end else begin
			case (tx_state_ff)
				SER_IDLE: begin
					if (tx_out_valid) begin
						tx_shift_ff <= tx_out_data & len_mask;
						tx_par_ff <= parity_of(tx_out_data & len_mask,
							line_ctrl_ff[LC_PAR_SEL +: 2]);
						tx_tick_ff <= '0;
						tx_bit_ff <= '0;
						tx_state_ff <= SER_START;
					end
				end
				SER_START, SER_DATA, SER_PARITY: begin
					if (tick && tx_tick_ff == TICKS_BIT - 6'd1) begin
						tx_tick_ff <= '0;
						if (tx_state_ff == SER_START)
							tx_state_ff <= SER_DATA;
						else if (tx_state_ff == SER_DATA &&
							tx_bit_ff != last_bit)
							tx_bit_ff <= tx_bit_ff + 3'd1;
						else if (tx_state_ff == SER_DATA && par_en)
							tx_state_ff <= SER_PARITY;
						else
							tx_state_ff <= SER_STOP;
					end else if (tick) begin
						tx_tick_ff <= tx_tick_ff + 6'd1;
					end
				end
				SER_STOP: begin
					if (tick && tx_tick_ff == stop_ticks - 6'd1)
						tx_state_ff <= SER_IDLE;
					else if (tick)
						tx_tick_ff <= tx_tick_ff + 6'd1;
				end
				default: tx_state_ff <= SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			tx_line_ff <= 1'b1;
		else if (line_ctrl_ff[LC_BREAK])
			tx_line_ff <= 1'b0;
		else if (tx_state_ff == SER_START)
			tx_line_ff <= 1'b0;
		else if (tx_state_ff == SER_DATA)
			tx_line_ff <= tx_shift_ff[tx_bit_ff];
		else if (tx_state_ff == SER_PARITY)
			tx_line_ff <= tx_par_ff;
		else
			tx_line_ff <= 1'b1;
	end

	// Receiver: samples each bit at its middle; bad stop bits drop the byte.
	ser_state_e rx_state_ff;
	logic [5:0] rx_tick_ff;
	logic [2:0] rx_bit_ff;
	logic [5:0] rx_limit;
	assign rx_limit = rx_state_ff == SER_START ? TICKS_HALF : TICKS_BIT;

	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_state_ff <= SER_IDLE;
			rx_tick_ff <= '0;
			rx_bit_ff <= '0;
			rx_shift_ff <= BYTE_ZERO;
			rx_push_ff <= 1'b0;
		end else begin
			rx_push_ff <= 1'b0;
			if (rx_state_ff == SER_IDLE) begin
				rx_tick_ff <= '0;
				rx_bit_ff <= '0;
				if (tick && !rx_line)
					rx_state_ff <= SER_START;
			end else if (tick && rx_tick_ff != rx_limit - 6'd1) begin
				rx_tick_ff <= rx_tick_ff + 6'd1;
			end else if (tick) begin
				rx_tick_ff <= '0;
				case (rx_state_ff)
					SER_START:
						rx_state_ff <= rx_line ? SER_IDLE : SER_DATA;
					SER_DATA: begin
						rx_shift_ff[rx_bit_ff] <= rx_line;
						rx_bit_ff <= rx_bit_ff + 3'd1;
						if (rx_bit_ff == last_bit)
							rx_state_ff <= par_en ? SER_PARITY : SER_STOP;
					end
					SER_PARITY: rx_state_ff <= SER_STOP;
					SER_STOP: begin
						rx_push_ff <= rx_line;
						rx_state_ff <= SER_IDLE;
					end
					default: rx_state_ff <= SER_IDLE;
				endcase
			end
		end
	end

	// Register read port, answered on the edge after the strobe.
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata_ff <= BYTE_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_DATA: reg_rdata_ff <= dlab ? divisor_ff[7:0] :
					(rx_out_valid ? rx_out_data : BYTE_ZERO);
				OFS_DIV_HIGH:
					reg_rdata_ff <= dlab ? divisor_ff[15:8] : BYTE_ZERO;
				OFS_SAMPLE: reg_rdata_ff <= dlab ? sample_ff : BYTE_ZERO;
				OFS_LINE_CTRL: reg_rdata_ff <= line_ctrl_ff;
				default: reg_rdata_ff <= BYTE_ZERO;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_ff;
	assign tx_line = tx_line_ff;
	assign rx_trigger_hit = rx_hit_ff;
	assign tx_trigger_low = tx_low_ff;
	assign tx_fifo_full = tx_full_ff;
endmodule : serial_channel

// >>> test/serial_channel_props.sv
// Concurrent checks on the serial channel's ports.
`timescale 1ns/1ps
module channel_checker #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic enhanced_mode,
	input wire logic rx_line,
	input wire logic tx_line,
	input wire logic rx_trigger_hit,
	input wire logic tx_trigger_low,
	input wire logic tx_fifo_full
);
	import line_fmt_pkg::*;
	logic [7:0] lc_ff, dl_ff, dh_ff, sc_ff, div_rd;
	logic dlab, fc_wr, brk;
	assign dlab = lc_ff[LC_DLAB];
	assign brk = lc_ff[LC_BREAK];
	assign fc_wr = reg_wr && !dlab && reg_addr == OFS_FIFO_CTRL;
	assign div_rd = reg_addr == OFS_DIV_LOW ? dl_ff :
		(reg_addr == OFS_DIV_HIGH ? dh_ff : sc_ff);
	always_ff @(posedge mclk) begin
		if (srst) begin
			lc_ff <= LINE_CTRL_RST;
		end else if (reg_wr && reg_addr == OFS_LINE_CTRL) begin
			lc_ff <= reg_wdata;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			dl_ff <= BYTE_ZERO;
			dh_ff <= BYTE_ZERO;
			sc_ff <= BYTE_ZERO;
		end else if (reg_wr && dlab) begin
			case (reg_addr)
				OFS_DIV_LOW: dl_ff <= reg_wdata;
				OFS_DIV_HIGH: dh_ff <= reg_wdata;
				OFS_SAMPLE: sc_ff <= reg_wdata;
				default: ;
			endcase
		end
	end
	// Counts the cells from start to parity of a frame at divisor one, so
	// that falling edges between data bits are not taken for start bits.
	logic [7:0] frm_ff;
	logic [3:0] cells;
	assign cells = 4'h6 + {2'h0, lc_ff[LC_LEN +: 2]} +
		{3'h0, lc_ff[LC_PAR_EN]};
	always_ff @(posedge mclk) begin
		if (srst)
			frm_ff <= 8'h00;
		else if (frm_ff != 8'h00)
			frm_ff <= frm_ff - 8'h01;
		else if ($fell(tx_line) && !brk)
			frm_ff <= {cells, 4'h0} - 8'h01;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_reset_outputs: assert property ($fell(srst) |-> tx_line &&
		tx_trigger_low && !rx_trigger_hit && !tx_fifo_full)
		else $error("outputs wrong after reset");
	a_lc_readback: assert property (reg_rd && reg_addr == OFS_LINE_CTRL
		|=> reg_rdata == $past(lc_ff)) else $error("line control read");
	a_fc_write_only: assert property (reg_rd && !dlab &&
		reg_addr == OFS_FIFO_CTRL |=> reg_rdata == BYTE_ZERO)
		else $error("fifo control readable");
	a_divisor_read: assert property (reg_rd && dlab && reg_addr <= 3'h2
		|=> reg_rdata == $past(div_rd)) else $error("divisor read");
	a_upper_zero: assert property (reg_rd && reg_addr[2]
		|=> reg_rdata == BYTE_ZERO) else $error("upper offset read");
	a_break_space: assert property (brk && $past(brk) |-> !tx_line)
		else $error("break not held");
	a_start_bit: assert property ($fell(tx_line) && !brk &&
		frm_ff == 8'h00 && !$past(brk) &&
		dl_ff == 8'h01 && dh_ff == BYTE_ZERO
		|-> !tx_line [*8] ##1 !tx_line [*8]) else $error("start bit");
	a_tx_flush: assert property (fc_wr && reg_wdata[FC_TX_FLUSH]
		|-> ##[1:3] tx_trigger_low && !tx_fifo_full)
		else $error("tx flush");
	a_rx_flush: assert property (fc_wr && reg_wdata[FC_RX_FLUSH]
		|-> ##[1:3] !rx_trigger_hit) else $error("rx flush");
	c_break: cover property (brk && !tx_line);
	c_full: cover property (tx_fifo_full && enhanced_mode);
	c_rx_hit: cover property ($fell(rx_line) ##[1:300] rx_trigger_hit);
endmodule : channel_checker

// >>> test/serial_partner.sv
// Remote serial transceiver model on the channel's line pins.
`timescale 1ns/1ps
module serial_partner (
	input wire logic mclk,
	input wire logic tx_line,
	output logic rx_line
);
	initial rx_line = 1'b1;
	// Sends one character with eight data bits and one stop bit.
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (16) @(posedge mclk);
		end
	endtask : send
	// Waits for a start edge and samples start and n bits mid-cell.
	task automatic grab(input int n, output logic [9:0] b, output int t);
		t = 0;
		b = '0;
		while (tx_line !== 1'b0) begin
			@(posedge mclk);
			t++;
		end
		repeat (8) @(posedge mclk);
		for (int i = 0; i <= n; i++) begin
			b[i] = tx_line;
			repeat (16) @(posedge mclk);
		end
	endtask : grab
endmodule : serial_partner

// >>> test/testbench.sv
// Self-checking bench for the serial channel.
`timescale 1ns/1ps
module testbench;
	import line_fmt_pkg::*;
	localparam int FIFO_DEPTH = 8;
	logic mclk = 1'b0;
	logic srst, reg_wr, reg_rd, enhanced_mode, rx_line, tx_line;
	logic rx_trigger_hit, tx_trigger_low, tx_fifo_full;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	always #4 mclk = ~mclk;
	serial_channel #(.FIFO_DEPTH(FIFO_DEPTH)) u_serial_channel (.mclk,
		.srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.enhanced_mode, .rx_line, .tx_line, .rx_trigger_hit,
		.tx_trigger_low, .tx_fifo_full);
	serial_partner u_serial_partner (.mclk, .tx_line, .rx_line);
	task automatic finish_test();
		if (bad_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk(16'(reg_rdata), 16'(e));
	endtask : rd
	task automatic do_reset();
		srst <= 1'b1;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : do_reset
	function automatic logic [15:0] frame_of(input logic [7:0] l,
		input logic [7:0] d);
		logic [15:0] f;
		logic p;
		int n;
		n = 5 + int'(l[1:0]);
		f = '0;
		p = 1'b0;
		for (int i = 0; i < n; i++) begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		if (l[3]) begin
			f[n + 1] = l[5] ? ~l[4] : (l[4] ? p : ~p);
		end
		return f;
	endfunction : frame_of
	task automatic t_regs();
		rd(OFS_LINE_CTRL, 8'h03);
		chk(16'({tx_line, tx_trigger_low, rx_trigger_hit}), 16'h6);
		wr(OFS_LINE_CTRL, 8'h80);
		wr(OFS_DIV_LOW, 8'h3C);
		wr(OFS_DIV_HIGH, 8'hC3);
		wr(OFS_SAMPLE, 8'h5A);
		rd(OFS_DIV_LOW, 8'h3C);
		rd(OFS_DIV_HIGH, 8'hC3);
		rd(OFS_SAMPLE, 8'h5A);
		rd(OFS_LINE_CTRL, 8'h80);
		wr(OFS_DIV_LOW, 8'h00);
		wr(OFS_DIV_HIGH, 8'h00);
		wr(OFS_LINE_CTRL, 8'h03);
		rd(OFS_FIFO_CTRL, 8'h00);
		rd(3'h7, 8'h00);
	endtask : t_regs
	// The divisor is zero here, so the transmitter stalls on the first character and the FIFO fills.
	task automatic t_fill();
		wr(OFS_FIFO_CTRL, 8'h01);
		for (int i = 0; i < 10; i++) begin
			wr(OFS_DATA, 8'(i));
		end
		chk(16'({tx_fifo_full, tx_trigger_low}), 16'h2);
		enhanced_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(16'(tx_trigger_low), 16'h1);
		enhanced_mode <= 1'b0;
		wr(OFS_FIFO_CTRL, 8'h05);
		repeat (3) @(posedge mclk);
		chk(16'({tx_fifo_full, tx_trigger_low}), 16'h1);
	endtask : t_fill
	task automatic t_frames();
		logic [7:0] l [6] = '{8'h03, 8'h04, 8'h1A, 8'h0D, 8'h2F, 8'h3B};
		logic [7:0] d [6] = '{8'hA5, 8'h13, 8'h5C, 8'h2B, 8'hC3, 8'h7E};
		logic [9:0] b1, b2;
		int t1, t2, n, s;
		wr(OFS_LINE_CTRL, 8'h80);
		wr(OFS_DIV_LOW, 8'h01);
		wr(OFS_LINE_CTRL, 8'h03);
		wr(OFS_FIFO_CTRL, 8'h01);
		for (int k = 0; k < 6; k++) begin
			wr(OFS_LINE_CTRL, l[k]);
			n = 5 + int'(l[k][1:0]) + int'(l[k][3]);
			s = l[k][2] ? (l[k][1:0] == 2'h0 ? 24 : 32) : 16;
			fork
				begin
					u_serial_partner.grab(n, b1, t1);
					u_serial_partner.grab(n, b2, t2);
				end
				begin
					wr(OFS_DATA, d[k]);
					wr(OFS_DATA, ~d[k]);
				end
			join
			chk(16'(b1), frame_of(l[k], d[k]));
			chk(16'(b2), frame_of(l[k], ~d[k]));
			chk(16'(t2 >= s - 8 && t2 <= s - 5), 16'h1);
			repeat (40) @(posedge mclk);
		end
	endtask : t_frames
	task automatic t_break();
		wr(OFS_LINE_CTRL, 8'h43);
		repeat (2) @(posedge mclk);
		chk(16'(tx_line), 16'h0);
		wr(OFS_LINE_CTRL, 8'h03);
		repeat (2) @(posedge mclk);
		chk(16'(tx_line), 16'h1);
	endtask : t_break
	task automatic t_rx();
		wr(OFS_FIFO_CTRL, 8'h41);
		for (int i = 0; i < 4; i++) begin
			u_serial_partner.send(8'h30 + 8'(i));
			repeat (4) @(posedge mclk);
			if (i == 2) begin
				chk(16'(rx_trigger_hit), 16'h0);
			end
		end
		chk(16'(rx_trigger_hit), 16'h1);
		enhanced_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(16'(rx_trigger_hit), 16'h0);
		enhanced_mode <= 1'b0;
		rd(OFS_DATA, 8'h30);
		wr(OFS_FIFO_CTRL, 8'h01);
		repeat (2) @(posedge mclk);
		chk(16'(rx_trigger_hit), 16'h1);
		enhanced_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(16'(rx_trigger_hit), 16'h0);
		enhanced_mode <= 1'b0;
		wr(OFS_FIFO_CTRL, 8'h43);
		rd(OFS_DATA, 8'h00);
	endtask : t_rx
	initial begin
		srst = 1'b1;
		reg_addr = 3'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		enhanced_mode = 1'b0;
		do_reset();
		t_regs();
		t_fill();
		do_reset();
		t_frames();
		t_break();
		t_rx();
		finish_test();
	end
endmodule : testbench
bind serial_channel channel_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.mclk,
	.srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
	.enhanced_mode, .rx_line, .tx_line, .rx_trigger_hit, .tx_trigger_low,
	.tx_fifo_full);
